// >>> sfla_pkg.sv
package sfla_pkg;

    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [7:0] SFLA_CTRL_OFS = 8'h00;      // buffer_control_reg
    localparam logic [7:0] SFLA_LEVEL_OFS = 8'h04;     // fill_count low byte
    localparam logic [7:0] SFLA_THR_HI_OFS = 8'h08;    // threshold upper bit at bit 2
    localparam logic [7:0] SFLA_THR_LO_OFS = 8'h0C;    // fill_threshold_low
    localparam logic [7:0] SFLA_DATA_OFS = 8'h10;      // buffer data port
    localparam logic [7:0] SFLA_IRQ_STAT_OFS = 8'h14;  // irq_status_first
    localparam logic [7:0] SFLA_IRQ_EN_OFS = 8'h18;    // irq_enable_first
    localparam logic [7:0] SFLA_IRQ_CLR_OFS = 8'h1C;   // write-one-to-clear

    // ****************************************
    // field positions
    // ****************************************
    localparam int SFLA_CTRL_CLEAR_BIT = 4;
    localparam int SFLA_CTRL_DEPTH_BIT = 7;
    localparam int SFLA_CTRL_FULLF_BIT = 6;
    localparam int SFLA_CTRL_EMPTYF_BIT = 5;
    localparam int SFLA_CTRL_CNT_HI_BIT = 0;
    localparam int SFLA_THR_HI_BIT = 2;
    localparam int SFLA_IRQ_ERR_BIT = 0;
    localparam int SFLA_IRQ_EMPTY_BIT = 1;
    localparam int SFLA_IRQ_FULL_BIT = 2;
    localparam int SFLA_IRQ_W = 3;

    // ****************************************
    // depths and reset values
    // ****************************************
    localparam logic [9:0] SFLA_DEPTH_LARGE = 10'd512;
    localparam logic [9:0] SFLA_DEPTH_SMALL = 10'd255;
    localparam logic [8:0] SFLA_THR_RESET = 9'h008;
    localparam logic [SFLA_IRQ_W-1:0] SFLA_IRQ_EN_RESET = 3'h0;

    typedef enum logic [1:0] {
        SFLA_RESP_OKAY = 2'b00,
        SFLA_RESP_SLVERR = 2'b10
    } sfla_resp_type;

    // status seen by the register file
    typedef struct packed {
        logic [9:0] count;
        logic near_full;
        logic near_empty;
    } sfla_stat_type;

endpackage : sfla_pkg

// >>> sfla_store.sv
`timescale 1ns/1ps
// byte store with clear, depth select and overflow detect
module sfla_store
    import sfla_pkg::*;
#(
    parameter int DEPTH = 512
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic clear,
    input wire logic small_mode,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    output logic [9:0] count,
    output logic overflow
);

    // pointer and count widths are fixed to a 512-byte store
    if (DEPTH != 512)
    begin : g_depth_check
        $error("sfla_store: only a 512-byte store is supported");
    end

    logic [7:0] mem [0:DEPTH-1];
    logic [8:0] wr_ptr;
    logic [8:0] rd_ptr;
    wire [9:0] limit = small_mode ? SFLA_DEPTH_SMALL : SFLA_DEPTH_LARGE;
    wire is_full = count >= limit;
    wire is_empty = count == 10'h000;
    wire do_wr = wr_en && !is_full;
    wire do_rd = rd_en && !is_empty;

    assign rd_data = mem[rd_ptr];

    // pointers and count; clear beats traffic in the same cycle
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_ptr <= 9'h000;
            rd_ptr <= 9'h000;
            count <= 10'h000;
        end
        else if (clear)
        begin
            wr_ptr <= 9'h000;
            rd_ptr <= 9'h000;
            count <= 10'h000;
        end
        else
        begin
            if (do_wr)
                wr_ptr <= wr_ptr + 9'h001;
            if (do_rd)
                rd_ptr <= rd_ptr + 9'h001;
            count <= count + {9'h000, do_wr} - {9'h000, do_rd};
        end
    end

    // storage array has no reset so it maps onto memory
    always_ff @(posedge clock)
    begin
        if (do_wr && !clear)
            mem[wr_ptr] <= wr_data;
    end

    // one-cycle pulse for a write refused while full
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            overflow <= 1'b0;
        else
            overflow <= wr_en && is_full && !clear;
    end

    property p_count_bound;
        @(posedge clock) disable iff (!nrst)
        count <= limit;
    endproperty
    a_count_bound: assert property (p_count_bound) else $error("fill count exceeds depth");

    property p_full_hold;
        @(posedge clock) disable iff (!nrst)
        (wr_en && is_full && !rd_en && !clear) |=> $stable(count) && overflow;
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("full write changed count");

    property p_empty_hold;
        @(posedge clock) disable iff (!nrst)
        (rd_en && is_empty && !wr_en && !clear) |=> count == 10'h000;
    endproperty
    a_empty_hold: assert property (p_empty_hold) else $error("empty read moved count");

endmodule : sfla_store

// >>> sfla_top.sv
`timescale 1ns/1ps
// Operation
// - clear bit resets pointers and count
// - clear gives 512 or 255 bytes room
// - count tracks writes and reads
// - threshold is nine bits over two registers
// - near-full when room at most threshold
// - near-empty when count at most threshold
// - one threshold serves both alerts
// - write while full sets overflow error
// - near-empty rise interrupts when enabled
// - near-full rise interrupts when enabled
// - small mode fits one byte, large two
module sfla_top
    import sfla_pkg::*;
#(
    parameter int DEPTH = 512
)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);

    // the store and the count view only serve a 512-byte buffer
    if (DEPTH != 512)
    begin : g_depth_check
        $error("sfla_top: only a 512-byte buffer is supported");
    end

    // ****************************************
    // write channel capture
    // ****************************************
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    // an item is held while its ready flop is low
    wire aw_held = !s_axi_awready;
    wire w_held = !s_axi_wready;
    wire wr_go = aw_held && w_held && !s_axi_bvalid;

    // address and data taken independently, in either order
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                s_axi_awready <= 1'b0;
                aw_addr <= s_axi_awaddr;
            end
            else if (wr_go)
                s_axi_awready <= 1'b1;
            if (s_axi_wvalid && s_axi_wready)
            begin
                s_axi_wready <= 1'b0;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (wr_go)
                s_axi_wready <= 1'b1;
        end
    end

    // ****************************************
    // write decode
    // ****************************************
    wire lane0 = w_strb[0];
    wire wr_ctrl = wr_go && lane0 && aw_addr == SFLA_CTRL_OFS;
    wire wr_thr_hi = wr_go && lane0 && aw_addr == SFLA_THR_HI_OFS;
    wire wr_thr_lo = wr_go && lane0 && aw_addr == SFLA_THR_LO_OFS;
    wire wr_data_port = wr_go && lane0 && aw_addr == SFLA_DATA_OFS;
    wire wr_irq_en = wr_go && lane0 && aw_addr == SFLA_IRQ_EN_OFS;
    wire wr_irq_clr = wr_go && lane0 && aw_addr == SFLA_IRQ_CLR_OFS;
    wire wr_known = aw_addr == SFLA_CTRL_OFS || aw_addr == SFLA_THR_HI_OFS
        || aw_addr == SFLA_THR_LO_OFS || aw_addr == SFLA_DATA_OFS
        || aw_addr == SFLA_IRQ_EN_OFS || aw_addr == SFLA_IRQ_CLR_OFS
        || aw_addr == SFLA_LEVEL_OFS || aw_addr == SFLA_IRQ_STAT_OFS;

    // write response
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SFLA_RESP_OKAY;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_known ? SFLA_RESP_OKAY : SFLA_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ****************************************
    // control registers
    // ****************************************
    logic depth_select;
    logic buffer_clear_bit;
    logic [8:0] fill_threshold;
    logic [SFLA_IRQ_W-1:0] irq_enable_first;

    // clear lives for one cycle only and reads back as zero
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            depth_select <= 1'b0;
            buffer_clear_bit <= 1'b0;
            fill_threshold <= SFLA_THR_RESET;
            irq_enable_first <= SFLA_IRQ_EN_RESET;
        end
        else
        begin
            buffer_clear_bit <= wr_ctrl && w_data[SFLA_CTRL_CLEAR_BIT];
            if (wr_ctrl)
                depth_select <= w_data[SFLA_CTRL_DEPTH_BIT];
            if (wr_thr_hi)
                fill_threshold[8] <= w_data[SFLA_THR_HI_BIT];
            if (wr_thr_lo)
                fill_threshold[7:0] <= w_data[7:0];
            if (wr_irq_en)
                irq_enable_first <= w_data[SFLA_IRQ_W-1:0];
        end
    end

    // ****************************************
    // buffer store and level alerts
    // ****************************************
    logic rd_pop;
    logic [7:0] buf_rdata;
    logic overflow_flag;
    sfla_stat_type stat;

    sfla_store #(.DEPTH(DEPTH)) u_store (
        .clock(clock),
        .nrst(nrst),
        .clear(buffer_clear_bit),
        .small_mode(depth_select),
        .wr_en(wr_data_port),
        .wr_data(w_data[7:0]),
        .rd_en(rd_pop),
        .rd_data(buf_rdata),
        .count(stat.count),
        .overflow(overflow_flag)
    );

    // one threshold measured from the top and from the bottom
    wire [9:0] depth_now = depth_select ? SFLA_DEPTH_SMALL : SFLA_DEPTH_LARGE;
    wire [9:0] room = depth_now - stat.count;
    assign stat.near_full = room <= {1'b0, fill_threshold};
    assign stat.near_empty = stat.count <= {1'b0, fill_threshold};

    // ****************************************
    // interrupt status
    // ****************************************
    logic near_full_d;
    logic near_empty_d;
    logic [SFLA_IRQ_W-1:0] irq_status_first;
    wire [SFLA_IRQ_W-1:0] irq_events = {stat.near_full && !near_full_d,
        stat.near_empty && !near_empty_d, overflow_flag};
    wire [SFLA_IRQ_W-1:0] irq_clear = wr_irq_clr ? w_data[SFLA_IRQ_W-1:0] : '0;

    // set wins over clear so no event is lost
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            near_full_d <= 1'b0;
            near_empty_d <= 1'b1;
            irq_status_first <= '0;
            irq <= 1'b0;
        end
        else
        begin
            near_full_d <= stat.near_full;
            near_empty_d <= stat.near_empty;
            irq_status_first <= (irq_status_first & ~irq_clear) | irq_events;
            irq <= |(((irq_status_first & ~irq_clear) | irq_events) & irq_enable_first);
        end
    end

    // ****************************************
    // read channel
    // ****************************************
    wire rd_take = s_axi_arvalid && s_axi_arready;
    assign rd_pop = rd_take && s_axi_araddr == SFLA_DATA_OFS;

    // readable state; fill count is split across two registers in large mode
    // two upper count bits, else a full 512-byte buffer would read as empty
    wire [31:0] ctrl_view = {24'h0, depth_select, stat.near_full, stat.near_empty,
        1'b0, 2'h0, stat.count[9:8]};
    wire rd_known = s_axi_araddr == SFLA_CTRL_OFS || s_axi_araddr == SFLA_LEVEL_OFS
        || s_axi_araddr == SFLA_THR_HI_OFS || s_axi_araddr == SFLA_THR_LO_OFS
        || s_axi_araddr == SFLA_DATA_OFS || s_axi_araddr == SFLA_IRQ_STAT_OFS
        || s_axi_araddr == SFLA_IRQ_EN_OFS || s_axi_araddr == SFLA_IRQ_CLR_OFS;
    wire [31:0] rd_mux =
        s_axi_araddr == SFLA_CTRL_OFS ? ctrl_view :
        s_axi_araddr == SFLA_LEVEL_OFS ? {24'h0, stat.count[7:0]} :
        s_axi_araddr == SFLA_THR_HI_OFS ? {29'h0, fill_threshold[8], 2'h0} :
        s_axi_araddr == SFLA_THR_LO_OFS ? {24'h0, fill_threshold[7:0]} :
        s_axi_araddr == SFLA_DATA_OFS ? {24'h0, buf_rdata} :
        s_axi_araddr == SFLA_IRQ_STAT_OFS ? {29'h0, irq_status_first} :
        s_axi_araddr == SFLA_IRQ_EN_OFS ? {29'h0, irq_enable_first} : 32'h0;

    // read answer one cycle after the address is taken
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= SFLA_RESP_OKAY;
        end
        else if (rd_take)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_known ? SFLA_RESP_OKAY : SFLA_RESP_SLVERR;
        end
        else if (s_axi_rready)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    property p_clear_zero;
        @(posedge clock) disable iff (!nrst)
        buffer_clear_bit |=> stat.count == 10'h000;
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("clear did not empty buffer");

    property p_clear_pulse;
        @(posedge clock) disable iff (!nrst)
        buffer_clear_bit |=> !buffer_clear_bit || $past(wr_ctrl);
    endproperty
    a_clear_pulse: assert property (p_clear_pulse) else $error("clear stuck high");

    property p_count_step;
        @(posedge clock) disable iff (!nrst)
        (wr_data_port && !rd_pop && !buffer_clear_bit && stat.count < depth_now)
            |=> stat.count == $past(stat.count) + 10'h001;
    endproperty
    a_count_step: assert property (p_count_step) else $error("write did not bump count");

    property p_full_alert;
        @(posedge clock) disable iff (!nrst)
        (stat.count <= depth_now)
            |-> stat.near_full == ({1'b0, stat.count} + {2'b00, fill_threshold} >= {1'b0, depth_now});
    endproperty
    a_full_alert: assert property (p_full_alert) else $error("near-full missing");

    property p_empty_alert;
        @(posedge clock) disable iff (!nrst)
        (stat.count == 10'h000) |-> stat.near_empty;
    endproperty
    a_empty_alert: assert property (p_empty_alert) else $error("near-empty missing at zero");

    property p_err_set;
        @(posedge clock) disable iff (!nrst)
        overflow_flag |=> irq_status_first[SFLA_IRQ_ERR_BIT];
    endproperty
    a_err_set: assert property (p_err_set) else $error("overflow not latched");

    property p_empty_irq;
        @(posedge clock) disable iff (!nrst)
        ($rose(stat.near_empty) && irq_enable_first[SFLA_IRQ_EMPTY_BIT]
            && !wr_irq_en) |=> irq;
    endproperty
    a_empty_irq: assert property (p_empty_irq) else $error("near-empty irq missing");

    property p_full_irq;
        @(posedge clock) disable iff (!nrst)
        ($rose(stat.near_full) && irq_enable_first[SFLA_IRQ_FULL_BIT]
            && !wr_irq_en) |=> irq;
    endproperty
    a_full_irq: assert property (p_full_irq) else $error("near-full irq missing");

endmodule : sfla_top

// >>> sfla_host_model.sv
`timescale 1ns/1ps
// ********************
// host bus master model
// ********************
module sfla_host_model
    import sfla_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    // idle bus at time zero; payloads start as junk, not zero
    initial
    begin
        s_axi_awaddr = 8'hFF;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'hFFFFFFFF;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'hFF;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
    end

    // one write at a time, so the shared store is never raced by the host
    task automatic write_reg(input logic [7:0] addr, input logic [31:0] data, output logic [1:0] resp);
        logic done;
        done = 1'b0;
        @(posedge clock);
        s_axi_awaddr <= addr;
        s_axi_wdata <= data;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done)
        begin
            @(posedge clock);
            // released payload is inverted so a stale value never looks valid
            if (s_axi_awvalid && s_axi_awready)
            begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~addr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~data;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : write_reg

    // status may be read whenever the host likes
    task automatic read_reg(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
        logic done;
        done = 1'b0;
        @(posedge clock);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done)
        begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~addr;
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                data = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask : read_reg
endmodule : sfla_host_model

// >>> tb.sv
`timescale 1ns/1ps
// ********************
// buffer level alert bench
// ********************
module tb
    import sfla_pkg::*;
;
    logic clock;
    logic nrst;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, irq;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int err_total;
    int comparisons;

    sfla_top #(.DEPTH(512)) uut (.clock(clock), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));

    sfla_host_model host (.clock(clock), .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // 250 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // ********************
    // helpers
    // ********************
    function automatic logic [7:0] pat(input int i);
        return i[7:0] ^ 8'hA5;
    endfunction : pat

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            $display("BAD at %0t: %s got %h want %h", $time, what, got, exp);
            err_total++;
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        host.write_reg(a, d, r);
    endtask : wr

    task automatic rd_expect(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic [1:0] r;
        host.read_reg(a, d, r);
        check(d, exp, what);
    endtask : rd_expect

    // pushes bytes from..to-1 of the pattern
    task automatic fill(input int from, input int to);
        for (int i = from; i < to; i++)
            wr(SFLA_DATA_OFS, {24'h0, pat(i)});
    endtask : fill

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    // hang guard, several times the expected run of about 3300 cycles
    initial
    begin
        #(4 * 40000);
        err_total++;
        $display("BAD at %0t: watchdog expired", $time);
        report_and_stop();
    end

    // ********************
    // tests
    // ********************
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        err_total = 0;
        comparisons = 0;
        nrst = 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        rd_expect(SFLA_CTRL_OFS, 32'h20, "ctrl reset");
        rd_expect(SFLA_LEVEL_OFS, 32'h00, "level reset");
        rd_expect(SFLA_THR_HI_OFS, 32'h00, "thr hi reset");
        rd_expect(SFLA_THR_LO_OFS, 32'h08, "thr lo reset");
        rd_expect(SFLA_IRQ_STAT_OFS, 32'h0, "status reset");
        rd_expect(SFLA_IRQ_EN_OFS, 32'h0, "enable reset");
        check({31'h0, irq}, 32'h0, "irq reset");
        rd_expect(SFLA_IRQ_CLR_OFS, 32'h0, "clear reads zero");
        host.write_reg(8'h20, 32'hFF, r);
        check({30'h0, r}, {30'h0, SFLA_RESP_SLVERR}, "unmapped write");
        host.read_reg(8'h20, d, r);
        check({30'h0, r}, {30'h0, SFLA_RESP_SLVERR}, "unmapped read resp");
        check(d, 32'h0, "unmapped read data");
        $display("test reset and map done");
        // near-empty crossing with the interrupt enabled, then masked and cleared
        wr(SFLA_IRQ_EN_OFS, 32'h2);
        fill(0, 9);
        rd_expect(SFLA_LEVEL_OFS, 32'h09, "count after 9");
        rd_expect(SFLA_CTRL_OFS, 32'h00, "above water");
        rd_expect(SFLA_DATA_OFS, {24'h0, pat(0)}, "first byte");
        rd_expect(SFLA_CTRL_OFS, 32'h20, "at water");
        rd_expect(SFLA_IRQ_STAT_OFS, 32'h2, "empty rise");
        check({31'h0, irq}, 32'h1, "irq on empty rise");
        wr(SFLA_IRQ_EN_OFS, 32'h0);
        rd_expect(SFLA_IRQ_STAT_OFS, 32'h2, "status sticky");
        check({31'h0, irq}, 32'h0, "irq masked");
        wr(SFLA_IRQ_CLR_OFS, 32'h2);
        rd_expect(SFLA_IRQ_STAT_OFS, 32'h0, "status cleared");
        for (int i = 1; i < 9; i++)
            rd_expect(SFLA_DATA_OFS, {24'h0, pat(i)}, "drain");
        host.read_reg(SFLA_DATA_OFS, d, r);
        rd_expect(SFLA_LEVEL_OFS, 32'h00, "empty read");
        $display("test near-empty done");
        // clear drops stored bytes and reads back zero
        fill(0, 3);
        wr(SFLA_CTRL_OFS, 32'h10);
        rd_expect(SFLA_CTRL_OFS, 32'h20, "after clear");
        rd_expect(SFLA_LEVEL_OFS, 32'h00, "count cleared");
        wr(SFLA_DATA_OFS, 32'h5A);
        rd_expect(SFLA_DATA_OFS, 32'h5A, "old bytes gone");
        $display("test clear done");
        // small depth: near-full at 247, overflow past 255
        wr(SFLA_CTRL_OFS, 32'h90);
        wr(SFLA_IRQ_EN_OFS, 32'h5);
        fill(0, 246);
        rd_expect(SFLA_CTRL_OFS, 32'h80, "room 9");
        fill(246, 247);
        rd_expect(SFLA_CTRL_OFS, 32'hC0, "room 8");
        rd_expect(SFLA_IRQ_STAT_OFS, 32'h4, "full rise");
        check({31'h0, irq}, 32'h1, "irq on full rise");
        fill(247, 255);
        rd_expect(SFLA_LEVEL_OFS, 32'hFF, "small holds 255");
        rd_expect(SFLA_IRQ_STAT_OFS, 32'h4, "no overflow yet");
        wr(SFLA_DATA_OFS, 32'hEE);
        rd_expect(SFLA_IRQ_STAT_OFS, 32'h5, "overflow");
        rd_expect(SFLA_LEVEL_OFS, 32'hFF, "count kept");
        rd_expect(SFLA_DATA_OFS, {24'h0, pat(0)}, "data kept");
        $display("test small depth done");
        // large depth: ten-bit count, nine-bit threshold, overflow past 512
        wr(SFLA_CTRL_OFS, 32'h10);
        wr(SFLA_IRQ_CLR_OFS, 32'h7);
        fill(0, 256);
        rd_expect(SFLA_CTRL_OFS, 32'h01, "count bit 8");
        rd_expect(SFLA_LEVEL_OFS, 32'h00, "count low");
        wr(SFLA_THR_HI_OFS, 32'h04);
        rd_expect(SFLA_CTRL_OFS, 32'h61, "threshold 264");
        wr(SFLA_THR_HI_OFS, 32'h00);
        fill(256, 512);
        rd_expect(SFLA_CTRL_OFS, 32'h42, "large full");
        rd_expect(SFLA_LEVEL_OFS, 32'h00, "large count low");
        wr(SFLA_IRQ_CLR_OFS, 32'h7);
        rd_expect(SFLA_IRQ_STAT_OFS, 32'h0, "no overflow at 512");
        wr(SFLA_DATA_OFS, 32'h33);
        rd_expect(SFLA_IRQ_STAT_OFS, 32'h1, "overflow 513");
        check({31'h0, irq}, 32'h1, "irq on overflow");
        $display("test large depth done");
        report_and_stop();
    end
endmodule : tb
